// ### hdl/aho_core.sv
// file: host output and control logic of a 16-bit sar converter
`timescale 1ns/1ps
`default_nettype none
module aho_core (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // host bus strobes
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic register_select,
  input wire logic bus_width_select,
  input wire logic burst_calibration,
  input wire logic interleave_calibration_n,
  input wire logic sample_trigger_n,
  // comparator decision from the analog core
  input wire logic comp_bit,
  // parallel data lanes
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  // status pins
  output logic done_n,
  output logic track_done_n,
  output logic precharge,
  output logic calibrating,
  // serial output
  output logic serial_bit_out,
  output logic serial_strobe,
  // buffered result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [15:0] res_data
);
  // synchronous strobe samples
  logic cs_n_r;
  logic cs_n_d_r;
  logic rd_n_r;
  logic trig_n_r;
  logic sel_r;
  logic bw_r;
  logic cal_r;
  logic cal_in_r;
  logic ilv_in_r;
  logic ilv_r;
  aho_pkg::aho_state_t st_r;
  aho_pkg::aho_state_t st_nxt;
  logic [4:0] cnt_r;
  logic [3:0] ph_r;
  logic [15:0] sar_r;
  logic [15:0] buf_r;
  logic byte_ptr_r;
  logic done_r;
  logic [3:0] done_age_r;
  logic [4:0] trk_cnt_r;
  logic trk_run_r;
  logic trk_done_r;
  logic [3:0] pre_cnt_r;
  logic [aho_pkg::SER_DLY-1:0] ser_pipe_r;
  logic [aho_pkg::SER_DLY-1:0] dec_pipe_r;
  logic rd_prev_r;
  logic [15:0] dout_r;
  logic [15:0] doe_r;
  logic ser_r;
  logic sclk_r;
  logic ser_new_r;

  // strobe decode, all on sampled pins
  wire rd_act = !cs_n_r && !rd_n_r;
  wire rd_start = rd_act && !rd_prev_r;
  wire cs_rise = cs_n_r && !cs_n_d_r;
  wire soft_rst = !cs_n_r && !sel_r && !trig_n_r;
  wire data_rd = rd_start && sel_r;
  wire stand_alone = !cs_n_r && !rd_n_r && sel_r && rd_prev_r;
  wire conv_start = (st_r == aho_pkg::AHO_TRACK) && !trig_n_r && !cal_r;
  // one decision per bit period, so each bit gets its own strobe pulse
  wire decide = (st_r == aho_pkg::AHO_CONV) && (ph_r == aho_pkg::SER_DLY);
  wire conv_end_bit = decide && (cnt_r == aho_pkg::BIT_LAST);
  wire xtra_end = (st_r == aho_pkg::AHO_XTRA) && (cnt_r == aho_pkg::INTERLEAVE_CALIBRATION_N_CYC);
  wire conv_end = (conv_end_bit && ilv_r) || xtra_end;
  wire cnt_step = (st_r != aho_pkg::AHO_CONV) || decide;
  wire dout_hold = rd_act && !rd_start && sel_r && !bw_r; // byte read keeps its byte
  wire [15:0] sar_nxt = sar_r | (comp_bit ? bit_mask(cnt_r) : 16'h0000);
  wire [7:0] sel_byte = byte_ptr_r ? buf_r[7:0] : buf_r[15:8];
  wire [7:0] status_w = status_byte(done_r, byte_ptr_r, trk_done_r, st_r);
  wire [15:0] rd_word = !sel_r ? {8'h00, status_w} : (bw_r ? buf_r : {8'h00, sel_byte});
  wire rd_dead = done_age_r == aho_pkg::DONE_CYC - 4'h1;

  // one-hot mask for the bit decided at step k, msb first
  function automatic logic [15:0] bit_mask(input logic [4:0] k);
    bit_mask = 16'h8000 >> k[3:0];
  endfunction

  // status byte assembly
  function automatic logic [7:0] status_byte(input logic dn, input logic bp,
                                             input logic td, input aho_pkg::aho_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[aho_pkg::ST_DONE] = dn; // low while a result waits
    v[aho_pkg::ST_TRKEND] = td; // low once the input is acquired
    v[aho_pkg::ST_BYTEPTR] = bp;
    v[aho_pkg::ST_TRACK] = (s == aho_pkg::AHO_TRACK);
    v[aho_pkg::ST_CONV] = (s == aho_pkg::AHO_CONV) || (s == aho_pkg::AHO_XTRA);
    v[aho_pkg::ST_CAL] = (s == aho_pkg::AHO_CAL);
    status_byte = v;
  endfunction

  // pin sampling
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_n_r <= 1'b1;
      cs_n_d_r <= 1'b1;
      rd_n_r <= 1'b1;
      trig_n_r <= 1'b1;
      sel_r <= 1'b0;
      bw_r <= 1'b1;
      cal_in_r <= 1'b0;
      ilv_in_r <= 1'b1;
      rd_prev_r <= 1'b0;
    end else if (ce) begin
      cs_n_r <= cs_n;
      cs_n_d_r <= cs_n_r;
      rd_n_r <= rd_n;
      trig_n_r <= sample_trigger_n;
      sel_r <= register_select;
      bw_r <= bus_width_select;
      cal_in_r <= burst_calibration;
      ilv_in_r <= interleave_calibration_n;
      rd_prev_r <= rd_act;
    end
  end

  // calibration controls latched on chip select rising
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      cal_r <= 1'b0;
      ilv_r <= 1'b1;
    end else if (ce && cs_rise) begin
      cal_r <= cal_in_r;
      ilv_r <= ilv_in_r;
    end
  end

  // conversion sequencer next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      aho_pkg::AHO_TRACK: begin
        if (cal_r) st_nxt = aho_pkg::AHO_CAL;
        else if (conv_start) st_nxt = aho_pkg::AHO_CONV;
      end
      aho_pkg::AHO_CONV: begin
        if (conv_end_bit) st_nxt = ilv_r ? aho_pkg::AHO_TRACK : aho_pkg::AHO_XTRA;
      end
      aho_pkg::AHO_XTRA: begin
        if (xtra_end) st_nxt = aho_pkg::AHO_TRACK;
      end
      aho_pkg::AHO_CAL: begin
        if (!cal_r) st_nxt = aho_pkg::AHO_TRACK;
      end
      default: st_nxt = aho_pkg::AHO_TRACK;
    endcase
  end

  // sequencer state and bit counter
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      st_r <= aho_pkg::AHO_TRACK;
      cnt_r <= '0;
      ph_r <= '0;
      sar_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
      if (st_nxt != st_r) cnt_r <= 5'h00;
      else if (cnt_step) cnt_r <= cnt_r + 5'h01;
      ph_r <= ((st_nxt != st_r) || decide) ? 4'h0 : ph_r + 4'h1;
      if (conv_start) sar_r <= '0;
      else if (decide) sar_r <= sar_nxt;
    end
  end

  // output buffer and byte pointer
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      buf_r <= '0;
      byte_ptr_r <= 1'b0;
    end else if (ce) begin
      if (conv_end) begin
        buf_r <= conv_end_bit ? sar_nxt : sar_r;
        byte_ptr_r <= 1'b0;
      end else if (data_rd && !bw_r) begin
        byte_ptr_r <= !byte_ptr_r;
      end
    end
  end

  // conversion-done flag and its age
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      done_r <= 1'b1;
      done_age_r <= '0;
    end else if (ce) begin
      if (conv_end) begin
        done_r <= 1'b0;
        done_age_r <= '0;
      end else if (!done_r) begin
        done_age_r <= done_age_r + 4'h1;
        if (stand_alone && rd_dead) done_r <= 1'b1;
        else if (!stand_alone && (data_rd || conv_start)) done_r <= 1'b1;
      end
    end
  end

  // track-done counter and pre-charge window
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      trk_cnt_r <= '0;
      trk_run_r <= 1'b0;
      trk_done_r <= 1'b1;
      pre_cnt_r <= '0;
    end else if (ce) begin
      if (conv_end) begin
        trk_cnt_r <= 5'h01;
        trk_run_r <= 1'b1;
        trk_done_r <= 1'b1;
        pre_cnt_r <= aho_pkg::PRECHG_CYC;
      end else begin
        if (trk_run_r) begin
          trk_cnt_r <= trk_cnt_r + 5'h01;
          if (trk_cnt_r == aho_pkg::TRACK_CYC) begin
            trk_done_r <= 1'b0;
            trk_run_r <= 1'b0;
          end
        end
        if (conv_start) trk_done_r <= 1'b1;
        if (pre_cnt_r != 4'h0) pre_cnt_r <= pre_cnt_r - 4'h1;
      end
    end
  end

  // serial bit delay line, four clocks after each decision
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_pipe_r <= '0;
      dec_pipe_r <= '0;
      ser_r <= 1'b0;
      sclk_r <= 1'b1;
      ser_new_r <= 1'b0;
    end else if (ce) begin
      ser_new_r <= dec_pipe_r[aho_pkg::SER_DLY-1];
      ser_pipe_r <= {ser_pipe_r[aho_pkg::SER_DLY-2:0], comp_bit};
      dec_pipe_r <= {dec_pipe_r[aho_pkg::SER_DLY-2:0], decide};
      if (dec_pipe_r[aho_pkg::SER_DLY-1]) ser_r <= ser_pipe_r[aho_pkg::SER_DLY-1];
      // strobe rises a clock after the data moved, so the receiver sees it settled
      if (dec_pipe_r[0]) sclk_r <= 1'b0;
      else if (ser_new_r) sclk_r <= 1'b1;
    end
  end

  // read data and drive enables
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_r <= '0;
      doe_r <= '0;
    end else if (ce) begin
      if (!dout_hold) dout_r <= rd_word;
      doe_r <= rd_act ? ((sel_r && bw_r) ? 16'hffff : 16'h00ff) : 16'h0000;
    end
  end

  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign done_n = done_r;
  assign track_done_n = trk_done_r;
  assign precharge = pre_cnt_r != 4'h0;
  assign calibrating = st_r == aho_pkg::AHO_CAL;
  assign serial_bit_out = ser_r;
  assign serial_strobe = sclk_r;

  // every finished result goes to the stream fifo, dropped when full
  aho_fifo #(.WIDTH(aho_pkg::RES_W), .DEPTH(aho_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(conv_end),
    .in_ready(),
    .in_data(conv_end_bit ? sar_nxt : sar_r),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  // done falls only on conversion end
  a_done_fall: assert property (@(posedge clk) disable iff (rst)
    (ce && $past(ce) && $fell(done_n)) |-> $past(conv_end))
    else $error("done fell without a conversion end");
  // stand-alone done pulse lasts four clocks
  a_done_pulse: assert property (@(posedge clk) disable iff (rst)
    (ce && conv_end && stand_alone) ##1 (ce && stand_alone)[*4] |=> done_n)
    else $error("stand-alone done pulse length wrong");
  // pointer back to upper byte on new result
  a_ptr_reset: assert property (@(posedge clk) disable iff (rst)
    (ce && conv_end && !soft_rst) |=> !byte_ptr_r)
    else $error("byte pointer not reset on new result");
  // byte read toggles pointer
  a_ptr_toggle: assert property (@(posedge clk) disable iff (rst)
    (ce && data_rd && !bw_r && !conv_end && !soft_rst) |=> byte_ptr_r != $past(byte_ptr_r))
    else $error("byte pointer did not toggle");
  // track done still high eight quiet clocks after done
  sequence s_end_quiet;
    (ce && conv_end && !soft_rst) ##1 (ce && !conv_end && !conv_start && !soft_rst)[*8];
  endsequence
  a_track_time: assert property (@(posedge clk) disable iff (rst)
    s_end_quiet |-> track_done_n)
    else $error("track done fell too early");
  // pre-charge window after conversion
  a_precharge: assert property (@(posedge clk) disable iff (rst)
    (ce && conv_end && !soft_rst) |=> precharge)
    else $error("pre-charge not entered");
  // low byte lanes enabled while read active
  a_oe_read: assert property (@(posedge clk) disable iff (rst)
    (ce && rd_act) |=> data_oe[7:0] == 8'hff)
    else $error("drivers not enabled during read");
  // strobe falls after a decision
  a_strobe_low: assert property (@(posedge clk) disable iff (rst)
    (ce && decide) |-> ##2 !serial_strobe)
    else $error("serial strobe not low after decision");
endmodule
`default_nettype wire

// ### common/aho_pkg.sv
// package: constants for the converter host output interface
package aho_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RES_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // done release deadline and stand-alone done pulse, master clocks
  localparam logic [3:0] DONE_CYC = 4'h4;
  // serial bit presentation delay after decision, master clocks
  localparam logic [3:0] SER_DLY = 4'h4;
  // track-done fall after done fall, master clocks
  localparam logic [4:0] TRACK_CYC = 5'h0f;
  // pre-charge length on entering track, master clocks
  localparam logic [3:0] PRECHG_CYC = 4'h6;
  // conversion: sixteen decisions, msb first, SER_DLY+1 clocks apart
  localparam logic [4:0] BIT_LAST = 5'h0f;
  // interleave extends a conversion by this many clocks plus one
  localparam logic [4:0] INTERLEAVE_CALIBRATION_N_CYC = 5'h14;
  // status bit positions
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_TRKEND = 3;
  localparam int unsigned ST_BYTEPTR = 4;
  localparam int unsigned ST_TRACK = 5;
  localparam int unsigned ST_CONV = 6;
  localparam int unsigned ST_CAL = 7;
  typedef enum logic [1:0] {
    AHO_TRACK = 2'b00,
    AHO_CONV = 2'b01,
    AHO_XTRA = 2'b11,
    AHO_CAL = 2'b10
  } aho_state_t;
endpackage

// ### hdl/aho_fifo.sv
// file: small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module aho_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty from the occupancy count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  // pointer and count update
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ### verif/aho_host_model.sv
// host-side model: bus read cycles and a serial bit receiver
`timescale 1ns/1ps
`default_nettype none
module aho_host_model (
  // clocking
  input wire logic clk,
  // commands from the bench
  input wire logic go,
  input wire logic park,
  // bus strobes and read data
  output logic cs_n,
  output logic rd_n,
  input wire logic [15:0] data_out,
  output logic [15:0] rdata,
  // serial receiver
  input wire logic serial_strobe,
  input wire logic serial_bit_out,
  output logic [15:0] ser_word
);
  int n = 0;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    rdata = 16'h0000;
    ser_word = 16'h0000;
  end
  // strobes move on the falling edge and stand for four rising edges
  always @(negedge clk) begin
    if (park) begin
      cs_n <= 1'b0;
      rd_n <= 1'b0;
    end else if ((n > 0 && n < 4) || (go && n == 0)) begin
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      n <= n + 1;
    end else begin
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      n <= 0;
    end
  end
  // read data is taken at the last rising edge of the cycle
  always @(posedge clk) begin
    if (n == 4) rdata <= data_out;
  end
  // serial data is taken on the strobe rise, msb first
  always @(posedge serial_strobe) begin
    ser_word <= {ser_word[14:0], serial_bit_out};
  end
endmodule
`default_nettype wire

// ### verif/adc_host_output_interface_bench.sv
// bench for the converter host output interface
`timescale 1ns/1ps
`default_nettype none
module adc_host_output_interface_bench;
  localparam logic [15:0] RES = 16'hff00;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, rd_n, go = 1'b0, park = 1'b0;
  logic register_select = 1'b1, bus_width_select = 1'b1;
  logic burst_calibration = 1'b0, sample_trigger_n = 1'b1;
  logic comp_bit = 1'b1, res_ready = 1'b1;
  logic [15:0] data_out, data_oe, res_data, rdata, ser_word;
  logic done_n, track_done_n, precharge, calibrating;
  logic serial_bit_out, serial_strobe, res_valid;
  int miscompares = 0, checks_done = 0, cyc = 0, nfall = 0, npre = 0, k, w;
  aho_core u_dut (.clk(clk), .rst(rst), .ce(1'b1), .cs_n(cs_n), .rd_n(rd_n),
    .register_select(register_select), .bus_width_select(bus_width_select),
    .burst_calibration(burst_calibration), .interleave_calibration_n(1'b1),
    .sample_trigger_n(sample_trigger_n), .comp_bit(comp_bit), .data_out(data_out),
    .data_oe(data_oe), .done_n(done_n), .track_done_n(track_done_n),
    .precharge(precharge), .calibrating(calibrating), .serial_bit_out(serial_bit_out),
    .serial_strobe(serial_strobe), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data));
  aho_host_model u_host (.clk(clk), .go(go), .park(park), .cs_n(cs_n), .rd_n(rd_n),
    .data_out(data_out), .rdata(rdata), .serial_strobe(serial_strobe),
    .serial_bit_out(serial_bit_out), .ser_word(ser_word));
  // 20 mhz clock
  always #25 clk = ~clk;
  // comparator answers 1 for eight decisions, then 0
  always @(negedge serial_strobe) nfall <= nfall + 1;
  always @(negedge clk) comp_bit <= (nfall < 8);
  always @(negedge clk) if (precharge === 1'b1) npre <= npre + 1;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic trig();
    nfall = 0;
    npre = 0;
    @(negedge clk);
    sample_trigger_n <= 1'b0;
    @(negedge clk);
    sample_trigger_n <= 1'b1;
    @(negedge clk);
  endtask
  task automatic wait_done();
    k = 0;
    while (done_n !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk(k < 200, "done never fell");
  endtask
  task automatic rd(input logic rs);
    @(negedge clk);
    register_select <= rs;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (5) @(negedge clk);
  endtask
  // full-width conversion, serial stream, track timing and status
  task automatic t_conv();
    bus_width_select <= 1'b1;
    trig();
    wait_done();
    k = 0;
    while (track_done_n !== 1'b0 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk(k == 15, "track done delay");
    chk(npre == 6, "precharge length");
    chk(ser_word === RES, "serial word");
    rd(1'b0);
    chk(rdata[aho_pkg::ST_DONE] === 1'b0 && done_n === 1'b0, "status read");
    rd(1'b1);
    chk(rdata === RES, "word read");
    chk(done_n === 1'b1, "done not released");
  endtask
  // byte reads, pointer flag, buffered result, pointer reset
  task automatic t_bytes();
    bus_width_select <= 1'b0;
    trig();
    wait_done();
    repeat (20) @(negedge clk);
    rd(1'b0);
    chk(rdata[aho_pkg::ST_BYTEPTR] === 1'b0, "pointer upper");
    rd(1'b1);
    chk(rdata[7:0] === RES[15:8], "upper byte");
    rd(1'b0);
    chk(rdata[aho_pkg::ST_BYTEPTR] === 1'b1, "pointer lower");
    rd(1'b1);
    chk(rdata[7:0] === RES[7:0], "lower byte");
    rd(1'b1);
    chk(rdata[7:0] === RES[15:8], "bytes alternate");
    trig();
    rd(1'b1);
    chk(rdata[7:0] === RES[7:0], "read during conversion");
    rd(1'b1);
    chk(rdata[7:0] === RES[15:8], "second read during conversion");
    wait_done();
    repeat (20) @(negedge clk);
    rd(1'b1);
    chk(rdata[7:0] === RES[15:8], "pointer reset");
  endtask
  // burst calibration latched on chip select rise
  task automatic t_cal();
    burst_calibration <= 1'b1;
    rd(1'b0);
    repeat (3) @(negedge clk);
    chk(calibrating === 1'b1, "cal start");
    burst_calibration <= 1'b0;
    rd(1'b0);
    repeat (40) @(negedge clk);
    chk(calibrating === 1'b0, "cal stop");
  endtask
  // stand-alone: strobes parked low, done pulses four clocks
  task automatic t_stand();
    bus_width_select <= 1'b1;
    register_select <= 1'b1;
    park <= 1'b1;
    trig();
    wait_done();
    w = 0;
    while (done_n === 1'b0 && w < 10) begin
      w++;
      @(negedge clk);
    end
    chk(w == 4, "done pulse width");
    chk(data_oe === 16'hffff && data_out === RES, "parked lanes");
    park <= 1'b0;
    repeat (20) @(negedge clk);
  endtask
  // fill the result fifo past full with a stalled reader, then drain
  task automatic t_fifo();
    res_ready <= 1'b0;
    repeat (9) begin
      trig();
      wait_done();
      repeat (20) @(negedge clk);
    end
    res_ready <= 1'b1;
    k = 0;
    repeat (20) begin
      if (res_valid === 1'b1) begin
        k++;
        chk(res_data === RES, "fifo word");
      end
      @(negedge clk);
    end
    chk(k == 8, "fifo depth");
  endtask
  // software reset in mid-conversion: no result may follow
  task automatic t_soft();
    trig();
    repeat (10) @(negedge clk);
    register_select <= 1'b0;
    sample_trigger_n <= 1'b0;
    park <= 1'b1;
    repeat (3) @(negedge clk);
    park <= 1'b0;
    sample_trigger_n <= 1'b1;
    repeat (100) @(negedge clk);
    chk(done_n === 1'b1 && calibrating === 1'b0, "soft reset");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    t_conv();
    t_bytes();
    t_stand();
    t_cal();
    t_soft();
    t_fifo();
    close_out();
  end
endmodule
`default_nettype wire
